// ==== rtl/dmbs_pkg.sv ====
// Package with the constants, carrier structs and state types of the memory board select block.
package dmbs_pkg;
	// Clock period and cycle milestones in nanoseconds.
	localparam int CLK_NS = 10;
	localparam int CAE_NS = 100;
	localparam int CAS_NS = 150;
	localparam int ACT_NS = 350;
	localparam int CYC_NS = 520;

	// A least time rounds up to whole clock cycles.
	function automatic int ns2cyc(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : ns2cyc

	localparam logic [5:0] CAE_CYC = 6'(ns2cyc(CAE_NS));
	localparam logic [5:0] CAS_CYC = 6'(ns2cyc(CAS_NS));
	localparam logic [5:0] ACT_CYC = 6'(ns2cyc(ACT_NS));
	localparam logic [5:0] CYC_CYC = 6'(ns2cyc(CYC_NS));

	// Register byte offsets and fields.
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] STAT_OFS = 4'h4;
	localparam int CTRL_PHAN_BIT = 0;
	localparam int CTRL_XRDY_BIT = 1;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [7:0] OUT_RST = 8'hFF;

	// Bus lines that the board listens to; everything else is ignored.
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] dout;
		logic memwrt;
		logic psync;
		logic phi2;
		logic sinp;
		logic sout;
		logic smemr;
		logic swo;
		logic pdbin;
		logic pwr;
		logic phantom;
		logic prot;
		logic unprot;
	} dmbs_bus_t;

	// Memory chip pins, all active low.
	typedef struct packed {
		logic [3:0] ras_n;
		logic cas_n;
		logic we_n;
		logic cs_n;
		logic [5:0] a0_n;
		logic [5:0] a1_n;
		logic [7:0] din_n;
	} dmbs_mem_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACT = 2'b01,
		ST_REC = 2'b10
	} dmbs_st_t;
endpackage : dmbs_pkg

// ==== rtl/dmbs_select.sv ====
// Bus-side page/board select, write latch and cycle control of a 16K dynamic memory board.
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps

// What this block does
// - Only listed bus lines are sampled; all other bus lines are ignored.
// - Each four-bit switch group compared to A12-A15 raises its match line.
// - Only the lowest-numbered matching page stays enabled.
// - During cycles prioritized matches drive page lines, selecting one row strobe.
// - Page pairs enable one of two six-bit address driver groups.
// - Board select is any match without input or output port status.
// - Protect-status and ready drivers enabled only when selected and not phantom-inhibited.
// - Read data driven only on select, memory read, data-in strobe, no phantom.
// - Write strobe leading edge latches a write only if selected and unprotected.
// - Protect line sets protection, unprotect line clears it, both only while selected; unused protect held low.
// - Protect-status output is low when the selected board is protected.
// - Ready high when ready, low forces waits; alternate ready pin selectable.
// - Clock trailing edge in sync or retry defers if busy, else starts read.
// - Clock trailing edge also clocks the wait flip-flop behind ready.
// - Sync qualifies read request; sync trailing edge samples status for refresh.
// - Write-out inhibits spontaneous refresh; memory-read low inhibits clocked refresh.
// - Write with front-panel strobe high is followed by a display read.
// - Array is four groups of eight one-bit chips, 4096 bytes each.
// - Twelve-bit chip address goes out as two successive six-bit halves.
// - Chip select held enabled; row strobe selects, write enable picks direction.
// - All memory chip pin signals are active low.
// - Row strobe latches A0-A5 as row, column strobe later A6-A11.
// - With phantom jumper fitted, phantom disables the board's bus drivers; otherwise no effect.
module dmbs_select (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic clk_en,
	input wire dmbs_pkg::dmbs_bus_t bus_in,
	input wire logic [15:0] page_sw,
	input wire logic pwrup_prot,
	input wire logic [3:0][7:0] mem_q_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output dmbs_pkg::dmbs_mem_t mem_out,
	output logic [7:0] di_data,
	output logic di_oe,
	output logic ps_o,
	output logic ps_oe,
	output logic prdy_o,
	output logic prdy_oe,
	output logic xrdy_o,
	output logic xrdy_oe,
	output logic board_sel,
	output logic retry_request,
	output logic spont_ref_inhibit,
	output logic clk_ref_inhibit
);
	// All state of the block in one word.
	typedef struct packed {
		dmbs_pkg::dmbs_bus_t s1;
		dmbs_pkg::dmbs_bus_t s2;
		logic phi2_d;
		logic psync_d;
		logic memwrt_d;
		dmbs_pkg::dmbs_st_t st;
		logic [5:0] cnt;
		logic we;
		logic [3:0] page;
		logic retry;
		logic wait_f;
		logic wr_pend;
		logic fp_read;
		logic prot;
		logic init;
		logic [7:0] out_data;
		logic spont_inh;
		logic clk_inh;
		logic [1:0] ctrl;
		logic ack;
		logic [31:0] rdata;
	} dmbs_state_t;

	dmbs_state_t state_reg;
	dmbs_state_t state_next;

	// Keeps the lowest-numbered match only.
	function automatic logic [3:0] lowest_one(input logic [3:0] m);
		return m & ~(m - 4'h1);
	endfunction : lowest_one

	logic [3:0] match;
	logic [3:0] prio;
	logic ph_eff;
	logic bsel;
	logic phi2_fall;
	logic psync_fall;
	logic memwrt_rise;
	logic cae;
	logic cas;
	logic ras;
	logic [5:0] mux_addr;
	logic busy;

	// Page compare on synchronised address against static switches.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			match[i] = (page_sw[i*4 +: 4] == state_reg.s2.addr[15:12]);
		end
	end

	// Selection terms and edges of the synchronised bus strobes.
	assign prio = lowest_one(match);
	assign ph_eff = state_reg.ctrl[dmbs_pkg::CTRL_PHAN_BIT] & state_reg.s2.phantom;
	assign bsel = (|match) & ~(state_reg.s2.sinp | state_reg.s2.sout);
	assign phi2_fall = state_reg.phi2_d & ~state_reg.s2.phi2;
	assign psync_fall = state_reg.psync_d & ~state_reg.s2.psync;
	assign memwrt_rise = ~state_reg.memwrt_d & state_reg.s2.memwrt;
	assign busy = (state_reg.st != dmbs_pkg::ST_IDLE);

	// Cycle milestones from the cycle counter.
	assign ras = (state_reg.st == dmbs_pkg::ST_ACT);
	assign cae = ras & (state_reg.cnt >= dmbs_pkg::CAE_CYC);
	assign cas = ras & (state_reg.cnt >= dmbs_pkg::CAS_CYC);
	assign mux_addr = cae ? state_reg.s2.addr[11:6] : state_reg.s2.addr[5:0];

	// Memory pins are all active low; chip select is wired enabled.
	always_comb begin
		mem_out.ras_n = ~(ras ? state_reg.page : 4'h0);
		mem_out.cas_n = ~cas;
		mem_out.we_n = ~(ras & state_reg.we);
		mem_out.cs_n = 1'b0;
		// Only one driver group toggles, which keeps peak current down.
		mem_out.a0_n = (|state_reg.page[1:0]) ? ~mux_addr : 6'h3F;
		mem_out.a1_n = (|state_reg.page[3:2]) ? ~mux_addr : 6'h3F;
		mem_out.din_n = ~state_reg.s2.dout;
	end

	// Bus-facing drivers; enables are combinational, data from flops.
	assign board_sel = bsel;
	assign di_data = state_reg.out_data;
	assign di_oe = bsel & state_reg.s2.smemr & state_reg.s2.pdbin & ~ph_eff;
	assign ps_oe = bsel & ~ph_eff;
	assign ps_o = ~state_reg.prot;
	assign prdy_oe = ps_oe & ~state_reg.ctrl[dmbs_pkg::CTRL_XRDY_BIT];
	assign xrdy_oe = ps_oe & state_reg.ctrl[dmbs_pkg::CTRL_XRDY_BIT];
	assign prdy_o = ~state_reg.wait_f;
	assign xrdy_o = ~state_reg.wait_f;
	assign retry_request = state_reg.retry;
	assign spont_ref_inhibit = state_reg.spont_inh;
	assign clk_ref_inhibit = state_reg.clk_inh;
	assign avs_readdata = state_reg.rdata;
	assign avs_waitrequest = (avs_read | avs_write) & ~state_reg.ack;

	// Next-state logic for the whole block.
	always_comb begin
		logic start_rd;
		logic start_wr;
		logic acc;
		start_rd = 1'b0;
		start_wr = 1'b0;
		acc = 1'b0;
		state_next = state_reg;
		// Two-stage synchroniser; only the second stage feeds logic.
		state_next.s1 = bus_in;
		state_next.s2 = state_reg.s1;
		state_next.phi2_d = state_reg.s2.phi2;
		state_next.psync_d = state_reg.s2.psync;
		state_next.memwrt_d = state_reg.s2.memwrt;

		// The strap is caught once, on the first enabled edge after reset.
		if (!state_reg.init) begin
			state_next.init = 1'b1;
			state_next.prot = pwrup_prot;
		end else if (bsel && state_reg.s2.prot) begin
			state_next.prot = 1'b1;
		end else if (bsel && state_reg.s2.unprot) begin
			state_next.prot = 1'b0;
		end

		// Read request on the trailing clock edge during sync or retry.
		if (phi2_fall) begin
			if (state_reg.s2.psync || state_reg.retry) begin
				if (busy) begin
					state_next.retry = 1'b1;
				end else begin
					state_next.retry = 1'b0;
					start_rd = 1'b1;
				end
			end
			// Wait follows a pending retry while selected.
			state_next.wait_f = state_next.retry & bsel;
		end

		// Status sampled at the end of sync steers refresh inhibits.
		if (psync_fall) begin
			state_next.spont_inh = state_reg.s2.swo;
			state_next.clk_inh = ~state_reg.s2.smemr;
		end

		// Cycle sequencer: active period, then recovery.
		unique case (state_reg.st)
			dmbs_pkg::ST_IDLE: begin
				if (!start_rd && state_reg.wr_pend) begin
					start_wr = 1'b1;
				end else if (!start_rd && state_reg.fp_read) begin
					state_next.fp_read = 1'b0;
					start_rd = 1'b1;
				end
				if (start_rd || start_wr) begin
					state_next.st = dmbs_pkg::ST_ACT;
					state_next.cnt = 6'h00;
					state_next.we = start_wr;
					state_next.wr_pend = state_reg.wr_pend & ~start_wr;
					state_next.page = prio;
				end
			end
			dmbs_pkg::ST_ACT: begin
				state_next.cnt = state_reg.cnt + 6'h01;
				if (state_reg.cnt == dmbs_pkg::ACT_CYC - 6'h01) begin
					state_next.st = dmbs_pkg::ST_REC;
					state_next.we = 1'b0;
					// Unselected cycles load all ones, not the old data.
					state_next.out_data = dmbs_pkg::OUT_RST;
					for (int i = 0; i < 4; i++) begin
						if (state_reg.page[i]) begin
							state_next.out_data = ~mem_q_n[i];
						end
					end
				end
			end
			dmbs_pkg::ST_REC: begin
				state_next.cnt = state_reg.cnt + 6'h01;
				if (state_reg.cnt == dmbs_pkg::CYC_CYC - 6'h01) begin
					state_next.st = dmbs_pkg::ST_IDLE;
					state_next.page = 4'h0;
				end
			end
			default: begin
				state_next.st = dmbs_pkg::ST_IDLE;
			end
		endcase

		// Write latch on the leading edge of the write strobe. It sits after the
		// sequencer so that a strobe in the cycle that takes an old request still wins.
		if (memwrt_rise && bsel && !state_reg.prot) begin
			state_next.wr_pend = 1'b1;
			state_next.fp_read = state_reg.s2.pwr;
		end

		// Avalon slave answers every request one cycle after it is seen.
		acc = (avs_read | avs_write) & ~state_reg.ack;
		state_next.ack = acc;
		// A write lands only at the edge where waitrequest is already low.
		if (avs_write && state_reg.ack && avs_address == dmbs_pkg::CTRL_OFS) begin
			state_next.ctrl = avs_writedata[1:0];
		end
		if (acc && avs_read) begin
			unique case (avs_address)
				dmbs_pkg::CTRL_OFS: state_next.rdata = {30'h0, state_reg.ctrl};
				dmbs_pkg::STAT_OFS: state_next.rdata = {24'h0, state_reg.clk_inh,
					state_reg.spont_inh, bsel, busy, state_reg.wr_pend,
					state_reg.wait_f, state_reg.retry, state_reg.prot};
				default: state_next.rdata = 32'h0;
			endcase
		end
	end

	// One register for all state; clock enable freezes it.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= '0;
			state_reg.out_data <= dmbs_pkg::OUT_RST;
			state_reg.ctrl <= dmbs_pkg::CTRL_RST;
			state_reg.st <= dmbs_pkg::ST_IDLE;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	chk_prio_single: assert property (@(posedge core_clk) disable iff (!arst_n)
		(match != 4'h0) |-> ($onehot(prio) && (prio & match) == prio
		&& (prio - 4'h1 & match) == 4'h0))
		else $error("page priority wrong");

	chk_bsel_port: assert property (@(posedge core_clk) disable iff (!arst_n)
		(state_reg.s2.sinp || state_reg.s2.sout) |-> !board_sel)
		else $error("board selected during port cycle");

	chk_ras_onehot: assert property (@(posedge core_clk) disable iff (!arst_n)
		$onehot0(~mem_out.ras_n) && (mem_out.ras_n == 4'hF || ras))
		else $error("row strobes not exclusive");

	chk_addr_half: assert property (@(posedge core_clk) disable iff (!arst_n)
		(mem_out.a0_n == 6'h3F) || (mem_out.a1_n == 6'h3F))
		else $error("both address groups driven");

	chk_drv_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
		(prdy_oe || xrdy_oe || ps_oe) |-> (board_sel && !ph_eff))
		else $error("status drivers enabled when not selected");

	chk_di_gate: assert property (@(posedge core_clk) disable iff (!arst_n)
		di_oe |-> (board_sel && state_reg.s2.smemr && state_reg.s2.pdbin && !ph_eff))
		else $error("read data driven without qualifiers");

	chk_ps_level: assert property (@(posedge core_clk) disable iff (!arst_n)
		(ps_oe && state_reg.prot) |-> !ps_o)
		else $error("protect status not low");

	chk_retry_defer: assert property (@(posedge core_clk) disable iff (!arst_n)
		(clk_en && phi2_fall && busy && (state_reg.s2.psync || state_reg.retry))
		|=> retry_request)
		else $error("retry not deferred");

	chk_read_start: assert property (@(posedge core_clk) disable iff (!arst_n)
		(clk_en && phi2_fall && !busy && (state_reg.s2.psync || state_reg.retry))
		|=> (state_reg.st == dmbs_pkg::ST_ACT && !retry_request && !state_reg.we))
		else $error("read cycle not started");

	chk_wr_protect: assert property (@(posedge core_clk) disable iff (!arst_n)
		(clk_en && memwrt_rise && state_reg.prot && !state_reg.wr_pend)
		|=> !state_reg.wr_pend)
		else $error("write latched while protected");

	chk_col_order: assert property (@(posedge core_clk) disable iff (!arst_n)
		(!mem_out.cas_n) |-> (cae && ras))
		else $error("column strobe before column address");

	// Address halves on the low driver group follow the column enable.
	chk_row_half: assert property (@(posedge core_clk) disable iff (!arst_n)
		(ras && !cae && (|state_reg.page[1:0])) |-> (mem_out.a0_n == ~state_reg.s2.addr[5:0]))
		else $error("row half not on address pins");

	chk_col_half: assert property (@(posedge core_clk) disable iff (!arst_n)
		(cae && (|state_reg.page[1:0])) |-> (mem_out.a0_n == ~state_reg.s2.addr[11:6]))
		else $error("column half not on address pins");

	// Chip select, data-in and write enable levels of the memory chips.
	chk_cs_tied: assert property (@(posedge core_clk) disable iff (!arst_n)
		mem_out.cs_n == 1'b0)
		else $error("chip select not enabled");

	chk_din_low: assert property (@(posedge core_clk) disable iff (!arst_n)
		mem_out.din_n == ~state_reg.s2.dout)
		else $error("data in pins not active low");

	chk_we_write: assert property (@(posedge core_clk) disable iff (!arst_n)
		!mem_out.we_n |-> (ras && state_reg.we))
		else $error("write enable outside a write cycle");

	// Flags that must move only at their own events; a slip in the wait flop shows as stray waits.
	chk_wait_clock: assert property (@(posedge core_clk) disable iff (!arst_n)
		!(clk_en && phi2_fall) |=> $stable(state_reg.wait_f))
		else $error("wait flop moved off the clock edge");

	chk_retry_wait: assert property (@(posedge core_clk) disable iff (!arst_n)
		(clk_en && phi2_fall) |=> (state_reg.wait_f == (state_reg.retry && $past(bsel))))
		else $error("wait flop does not follow retry");

	chk_prot_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
		(clk_en && !board_sel && state_reg.init) |=> $stable(state_reg.prot))
		else $error("protect changed while unselected");

	chk_fp_follow: assert property (@(posedge core_clk) disable iff (!arst_n)
		(clk_en && memwrt_rise && board_sel && !state_reg.prot && state_reg.s2.pwr)
		|=> (state_reg.fp_read && state_reg.wr_pend))
		else $error("panel write not latched with its read");

	chk_refresh_inh: assert property (@(posedge core_clk) disable iff (!arst_n)
		(clk_en && psync_fall) |=> (spont_ref_inhibit == $past(state_reg.s2.swo)
		&& clk_ref_inhibit == !$past(state_reg.s2.smemr)))
		else $error("refresh inhibits not sampled at sync end");
endmodule : dmbs_select

// ==== verif/dmbs_host.sv ====
// Behavioural bus host that drives the board's bus lines from its own bus clock.
`timescale 1ns/100ps
module dmbs_host (
	output dmbs_pkg::dmbs_bus_t bus
);
	// The bus clock runs free at 8 MHz, unrelated in phase to the core clock.
	initial begin
		bus = '0;
		#3.7;
		forever #62.5 bus.phi2 = ~bus.phi2;
	end

	// Address only; status lines are left alone.
	task automatic set_addr(input logic [15:0] a);
		bus.addr = a;
	endtask : set_addr

	// Protect is held low whenever the test does not use it.
	task automatic lines(input logic p, input logic u, input logic ph, input logic si);
		bus.prot = p;
		bus.unprot = u;
		bus.phantom = ph;
		bus.sinp = si;
	endtask : lines

	// Sync must be gone before the next falling clock, or a second read would be requested.
	task automatic rd_cycle(input logic [15:0] a);
		@(posedge bus.phi2);
		bus.addr = a;
		bus.smemr = 1'b1;
		bus.psync = 1'b1;
		@(negedge bus.phi2);
		fork
			begin
				@(posedge bus.phi2);
				bus.psync = 1'b0;
				bus.pdbin = 1'b1;
			end
		join_none
	endtask : rd_cycle

	// Sync and write-out status by hand; a sync across a falling clock asks for a read.
	task automatic sync_lines(input logic s, input logic wo);
		bus.psync = s;
		bus.swo = wo;
	endtask : sync_lines

	// Ends a read by dropping status and data-in strobe.
	task automatic idle();
		bus.smemr = 1'b0;
		bus.pdbin = 1'b0;
	endtask : idle

	// Write strobe rises on a falling clock and stays up three and a half bus clocks.
	task automatic wr_cycle(input logic [15:0] a, input logic [7:0] d, input logic pw);
		@(posedge bus.phi2);
		bus.addr = a;
		bus.dout = d;
		bus.swo = 1'b1;
		bus.pwr = pw;
		@(negedge bus.phi2);
		bus.memwrt = 1'b1;
		repeat (4) @(posedge bus.phi2);
		bus.memwrt = 1'b0;
		bus.swo = 1'b0;
		bus.pwr = 1'b0;
		bus.dout = ~d;
	endtask : wr_cycle
endmodule : dmbs_host

// ==== verif/dmbs_select_test.sv ====
// Self-checking bench for the memory board select block.
`timescale 1ns/100ps
module dmbs_select_test;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	dmbs_pkg::dmbs_bus_t bus;
	logic [15:0] page_sw = 16'hF223;
	logic [3:0][7:0] mem_q_n = '1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	dmbs_pkg::dmbs_mem_t mem_out;
	logic [7:0] di_data;
	logic di_oe;
	logic ps_o;
	logic ps_oe;
	logic prdy_oe;
	logic prdy_o;
	logic xrdy_o;
	logic xrdy_oe;
	logic retry_request;
	logic spont_ref_inhibit;
	logic clk_ref_inhibit;
	logic clk_en = 1'b1;
	logic pwrup_prot = 1'b0;
	logic ras_was = 1'b0;
	int ras_count = 0;
	logic board_sel;
	logic [31:0] rd;
	logic we_seen = 1'b0;
	logic [7:0] din_cap = 8'h00;
	int bad_count = 0;
	int n_tests = 0;

	dmbs_host dmbs_host_i (.bus(bus));
	dmbs_select dmbs_select_i (.core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en),
		.bus_in(bus), .page_sw(page_sw), .pwrup_prot(pwrup_prot), .mem_q_n(mem_q_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .mem_out(mem_out), .di_data(di_data),
		.di_oe(di_oe), .ps_o(ps_o), .ps_oe(ps_oe), .prdy_o(prdy_o), .prdy_oe(prdy_oe),
		.xrdy_o(xrdy_o), .xrdy_oe(xrdy_oe), .board_sel(board_sel),
		.retry_request(retry_request), .spont_ref_inhibit(spont_ref_inhibit),
		.clk_ref_inhibit(clk_ref_inhibit));

	// Core clock, 10 ns period.
	always #5 core_clk = ~core_clk;

	// Remember any write strobe and the data presented with it, and count row strobes.
	always @(posedge core_clk) begin
		ras_was <= (mem_out.ras_n !== 4'hF);
		if (mem_out.ras_n !== 4'hF && !ras_was) begin
			ras_count <= ras_count + 1;
		end
		if (mem_out.we_n === 1'b0) begin
			we_seen <= 1'b1;
			din_cap <= ~mem_out.din_n;
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim

	// One register access; the request stands until waitrequest is seen low at a rising edge.
	task automatic av(input logic w, input logic [3:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= !w;
		avs_write <= w;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		chk(n < 50, 1, "bus hang");
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : av

	// Bounded wait for the row strobes to go active or idle.
	task automatic wait_ras(input logic idle);
		int n;
		n = 0;
		while ((mem_out.ras_n === 4'hF) != idle && n < 300) begin
			@(negedge core_clk);
			n++;
		end
		chk(n < 300, 1, "ras timeout");
	endtask : wait_ras

	// Bus lines pass two flops, so a few cycles let them land.
	task automatic settle();
		repeat (8) @(negedge core_clk);
	endtask : settle

	task automatic t_regs();
		dmbs_host_i.set_addr(16'h2000);
		av(1'b1, dmbs_pkg::CTRL_OFS, 32'h2);
		av(1'b0, dmbs_pkg::CTRL_OFS, 32'h0);
		chk(rd, 32'h2, "ctrl readback");
		av(1'b0, 4'h8, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		settle();
		chk(prdy_oe, 1'b0, "prdy with alt ready");
		chk(xrdy_oe, 1'b1, "alt ready drive");
		av(1'b0, dmbs_pkg::STAT_OFS, 32'h0);
		chk(rd, 32'h20, "status word");
		av(1'b1, dmbs_pkg::CTRL_OFS, 32'h0);
		settle();
		chk(prdy_oe, 1'b1, "prdy drive");
		chk(xrdy_oe, 1'b0, "alt ready off");
		$display("t_regs done");
	endtask : t_regs

	task automatic t_select();
		dmbs_host_i.set_addr(16'h2ABC);
		settle();
		chk(board_sel, 1'b1, "select on match");
		dmbs_host_i.lines(1'b0, 1'b0, 1'b0, 1'b1);
		settle();
		chk(board_sel, 1'b0, "port status");
		dmbs_host_i.lines(1'b0, 1'b0, 1'b0, 1'b0);
		settle();
		@(posedge core_clk);
		clk_en <= 1'b0;
		dmbs_host_i.set_addr(16'h5000);
		settle();
		chk(board_sel, 1'b1, "frozen by clock enable");
		@(posedge core_clk);
		clk_en <= 1'b1;
		settle();
		chk(board_sel, 1'b0, "no match");
		$display("t_select done");
	endtask : t_select

	task automatic t_read();
		mem_q_n <= {~8'h33, ~8'h33, ~8'h96, ~8'h33};
		dmbs_host_i.rd_cycle(16'h2A5C);
		wait_ras(1'b0);
		@(negedge core_clk);
		chk(mem_out.ras_n, 4'hD, "lowest page");
		chk(mem_out.a0_n, 6'h23, "row half");
		chk(mem_out.a1_n, 6'h3F, "idle group");
		chk(mem_out.cs_n, 1'b0, "chip select");
		repeat (12) @(negedge core_clk);
		chk(mem_out.a0_n, 6'h16, "column half");
		wait_ras(1'b1);
		settle();
		chk(di_oe, 1'b1, "read drive");
		chk(di_data, 8'h96, "read data");
		chk(we_seen, 1'b0, "read no write");
		dmbs_host_i.idle();
		settle();
		chk(di_oe, 1'b0, "drive off");
		$display("t_read done");
	endtask : t_read

	task automatic t_prot();
		dmbs_host_i.set_addr(16'h2000);
		dmbs_host_i.lines(1'b1, 1'b0, 1'b0, 1'b0);
		settle();
		dmbs_host_i.lines(1'b0, 1'b0, 1'b0, 1'b0);
		chk(ps_o, 1'b0, "protected");
		chk(ps_oe, 1'b1, "ps drive");
		we_seen <= 1'b0;
		dmbs_host_i.wr_cycle(16'h2003, 8'h5A, 1'b0);
		repeat (80) @(negedge core_clk);
		chk(we_seen, 1'b0, "blocked write");
		dmbs_host_i.lines(1'b0, 1'b1, 1'b0, 1'b0);
		settle();
		dmbs_host_i.lines(1'b0, 1'b0, 1'b0, 1'b0);
		chk(ps_o, 1'b1, "unprotected");
		dmbs_host_i.wr_cycle(16'h2003, 8'hC3, 1'b0);
		repeat (80) @(negedge core_clk);
		chk(we_seen, 1'b1, "write done");
		chk(din_cap, 8'hC3, "write data");
		dmbs_host_i.set_addr(16'h5000);
		dmbs_host_i.lines(1'b1, 1'b0, 1'b0, 1'b0);
		settle();
		dmbs_host_i.lines(1'b0, 1'b0, 1'b0, 1'b0);
		dmbs_host_i.set_addr(16'h2000);
		settle();
		chk(ps_o, 1'b1, "unselected protect");
		$display("t_prot done");
	endtask : t_prot

	task automatic t_phantom();
		av(1'b1, dmbs_pkg::CTRL_OFS, 32'h1);
		dmbs_host_i.lines(1'b0, 1'b0, 1'b1, 1'b0);
		settle();
		chk(ps_oe, 1'b0, "phantom ps");
		chk(prdy_oe, 1'b0, "phantom ready");
		av(1'b1, dmbs_pkg::CTRL_OFS, 32'h0);
		settle();
		chk(ps_oe, 1'b1, "no jumper");
		dmbs_host_i.lines(1'b0, 1'b0, 1'b0, 1'b0);
		$display("t_phantom done");
	endtask : t_phantom

	// Panel write, its follow-up read and a read deferred behind it, then refresh inhibits.
	task automatic t_front();
		int rc;
		rc = ras_count;
		dmbs_host_i.wr_cycle(16'h2003, 8'h11, 1'b1);
		dmbs_host_i.rd_cycle(16'h2003);
		repeat (6) @(negedge core_clk);
		chk(retry_request, 1'b1, "deferred read");
		chk(prdy_o, 1'b0, "wait on retry");
		chk(xrdy_o, 1'b0, "alt wait on retry");
		repeat (60) @(negedge core_clk);
		chk(retry_request, 1'b0, "retry served");
		chk(prdy_o, 1'b1, "ready again");
		chk(spont_ref_inhibit, 1'b0, "read allows refresh");
		chk(clk_ref_inhibit, 1'b0, "read allows clocked refresh");
		repeat (60) @(negedge core_clk);
		chk(ras_count - rc, 3, "write, panel read, retried read");
		chk(din_cap, 8'h11, "panel write data");
		dmbs_host_i.idle();
		dmbs_host_i.sync_lines(1'b1, 1'b1);
		repeat (30) @(negedge core_clk);
		dmbs_host_i.sync_lines(1'b0, 1'b1);
		settle();
		chk(spont_ref_inhibit, 1'b1, "write-out inhibit");
		chk(clk_ref_inhibit, 1'b1, "clocked inhibit");
		dmbs_host_i.sync_lines(1'b0, 1'b0);
		$display("t_front done");
	endtask : t_front

	// A second reset in mid-run with the power-up protect strap set.
	task automatic t_reset();
		@(posedge core_clk);
		pwrup_prot <= 1'b1;
		arst_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		arst_n <= 1'b1;
		settle();
		chk(ps_o, 1'b0, "power-up protect");
		chk(retry_request, 1'b0, "retry cleared");
		$display("t_reset done");
	endtask : t_reset

	// Main sequence after a 20-cycle reset.
	initial begin
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		t_regs();
		t_select();
		t_read();
		t_prot();
		t_front();
		t_phantom();
		t_reset();
		end_sim();
	end

	// Tests need well under 10 us; a hang is cut at 200 us.
	initial begin
		#200000;
		bad_count++;
		end_sim();
	end
endmodule : dmbs_select_test
